// ===== rtl/fes_pkg.sv
// Constants, op codes and carrier types for the erase-suspend flash host.
// Assumes a 125 MHz host clock and a word-mode (x16) flash on a 21-bit address bus.
package fes_pkg;
   localparam int CLK_NS = 8;
   localparam int WE_PULSE_NS = 35;
   localparam int READ_ACC_NS = 70;
   localparam int SUSPEND_MAX_US = 35;
   localparam int ERASE_TMO_US = 50;
   // Least times round up, the time-out window rounds down
   localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SUSPEND_CYC = (SUSPEND_MAX_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int ERASE_TMO_CYC = (ERASE_TMO_US * 1000) / CLK_NS;

   localparam logic [20:0] ADDR_UNLOCK1 = 21'h000555;
   localparam logic [20:0] ADDR_UNLOCK2 = 21'h0002aa;
   localparam logic [20:0] ADDR_DONT_CARE = 21'h000000;
   localparam logic [15:0] DATA_UNLOCK1 = 16'h00aa;
   localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
   localparam logic [15:0] DATA_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] DATA_SECTOR_ERASE = 16'h0030;
   localparam logic [15:0] DATA_RESUME = 16'h0030;
   localparam logic [15:0] DATA_SUSPEND = 16'h00b0;
   localparam logic [15:0] DATA_BYPASS_ENTER = 16'h0020;
   localparam logic [15:0] DATA_BYPASS_PROG = 16'h00a0;
   localparam logic [15:0] DATA_BYPASS_EXIT1 = 16'h0090;
   localparam logic [15:0] DATA_BYPASS_EXIT2 = 16'h0000;
   localparam int BANK_HI = 20;
   localparam int BANK_LO = 18;
   localparam int SECTOR_HI = 20;
   localparam int SECTOR_LO = 12;
   localparam int POLL_BIT = 7;

   typedef enum logic [6:0] {
      OP_READ = 7'h01,
      OP_SECTOR_ERASE = 7'h02,
      OP_SUSPEND = 7'h04,
      OP_RESUME = 7'h08,
      OP_BYPASS_ENTER = 7'h10,
      OP_BYPASS_PROG = 7'h20,
      OP_BYPASS_EXIT = 7'h40
   } fes_op_t;

   typedef struct packed {
      fes_op_t op;
      logic [20:0] addr;
      logic [15:0] data;
   } fes_req_t;

   typedef struct packed {
      logic [20:0] addr;
      logic [15:0] data;
      logic is_read;
      logic last;
   } fes_cyc_t;
endpackage : fes_pkg

// ===== rtl/fes_host.sv
// Host controller that drives a banked parallel flash through its bus pins.
// Assumes flash pins are synchronous to ref_clk; the data bus is split into in/out/enable.
`timescale 1ns/100ps
module fes_host
   import fes_pkg::*;
#(
   parameter int SUSPEND_WAIT = SUSPEND_CYC,
   parameter int ERASE_WINDOW = ERASE_TMO_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire fes_req_t req,
   output logic req_ready,
   output logic done,
   output logic refused,
   output logic [15:0] rd_data,
   output logic erase_busy,
   output logic erase_suspended,
   output logic bypass_active,
   output logic [20:0] flash_addr,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n
);
   typedef enum logic [3:0] {
      B_IDLE = 4'h1,
      B_SETUP = 4'h2,
      B_STROBE = 4'h4,
      B_HOLD = 4'h8
   } fes_bus_t;

   typedef enum logic [3:0] {
      E_IDLE = 4'h1,
      E_ERASING = 4'h2,
      E_SUSPENDING = 4'h4,
      E_SUSPENDED = 4'h8
   } fes_erase_t;

   fes_bus_t bus_state;
   fes_erase_t es_state;
   fes_req_t cur;
   logic [2:0] step;
   logic [3:0] cnt;
   logic [15:0] tmo;
   logic [15:0] wait_cnt;
   logic [20:0] erase_addr;
   fes_cyc_t cyc;

   // Legal host commands for the present erase and bypass state
   function automatic logic op_legal(input fes_op_t op, input fes_erase_t es,
                                     input logic byp);
      case (op)
         OP_READ: op_legal = (es != E_SUSPENDING);
         OP_SECTOR_ERASE: op_legal = (es == E_IDLE) && !byp;
         OP_SUSPEND: op_legal = (es == E_ERASING);
         OP_RESUME: op_legal = (es == E_SUSPENDED);
         OP_BYPASS_ENTER: op_legal = (es == E_IDLE) && !byp;
         // Bypass programs only with no erase pending, so never into a suspended erase
         OP_BYPASS_PROG: op_legal = (es == E_IDLE) && byp;
         OP_BYPASS_EXIT: op_legal = byp;
         default: op_legal = 1'b0;
      endcase
   endfunction : op_legal

   // Address and data of each bus cycle of a command
   function automatic fes_cyc_t seq_cycle(input fes_req_t r, input logic [2:0] s,
                                          input logic [20:0] ea);
      fes_cyc_t c;
      c = '{addr: ADDR_DONT_CARE, data: 16'h0000, is_read: 1'b0, last: 1'b1};
      case (r.op)
         OP_READ: begin
            c.addr = r.addr;
            c.is_read = 1'b1;
         end
         OP_SECTOR_ERASE: begin
            c.last = (s == 3'd5);
            c.addr = (s == 3'd5) ? r.addr :
                     (s == 3'd1 || s == 3'd4) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
            c.data = (s == 3'd5) ? DATA_SECTOR_ERASE : (s == 3'd2) ? DATA_ERASE_SETUP :
                     (s == 3'd1 || s == 3'd4) ? DATA_UNLOCK2 : DATA_UNLOCK1;
         end
         OP_SUSPEND, OP_RESUME: begin
            c.addr = ea;
            c.data = (r.op == OP_SUSPEND) ? DATA_SUSPEND : DATA_RESUME;
         end
         OP_BYPASS_ENTER: begin
            c.last = (s == 3'd2);
            c.addr = (s == 3'd1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
            c.data = (s == 3'd0) ? DATA_UNLOCK1 :
                     (s == 3'd1) ? DATA_UNLOCK2 : DATA_BYPASS_ENTER;
         end
         OP_BYPASS_PROG: begin
            c.last = (s == 3'd1);
            c.addr = (s == 3'd0) ? ADDR_DONT_CARE : r.addr;
            c.data = (s == 3'd0) ? DATA_BYPASS_PROG : r.data;
         end
         default: begin
            c.last = (s == 3'd1);
            c.data = (s == 3'd0) ? DATA_BYPASS_EXIT1 : DATA_BYPASS_EXIT2;
         end
      endcase
      seq_cycle = c;
   endfunction : seq_cycle

   assign cyc = seq_cycle(cur, step, erase_addr);
   assign erase_suspended = es_state[3];

   // Bus cycle sequencer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= B_IDLE;
         cur <= '{op: OP_READ, addr: 21'h000000, data: 16'h0000};
         step <= 3'h0;
         cnt <= 4'h0;
         req_ready <= 1'b1;
         done <= 1'b0;
         refused <= 1'b0;
         rd_data <= 16'h0000;
         flash_addr <= 21'h000000;
         flash_dq_out <= 16'h0000;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_oe_n <= 1'b1;
      end else begin
         done <= 1'b0;
         refused <= 1'b0;
         case (bus_state)
            B_IDLE: begin
               if (req_valid && req_ready) begin
                  if (op_legal(req.op, es_state, bypass_active)) begin
                     cur <= req;
                     step <= 3'h0;
                     req_ready <= 1'b0;
                     bus_state <= B_SETUP;
                  end else begin
                     refused <= 1'b1;
                  end
               end
            end
            B_SETUP: begin
               flash_addr <= cyc.addr;
               flash_dq_out <= cyc.data;
               flash_dq_oe <= !cyc.is_read;
               flash_ce_n <= 1'b0;
               flash_we_n <= cyc.is_read;
               flash_oe_n <= !cyc.is_read;
               cnt <= 4'h1;
               bus_state <= B_STROBE;
            end
            B_STROBE: begin
               cnt <= cnt + 4'h1;
               if (cnt == (cyc.is_read ? 4'(READ_CYC) : 4'(WE_CYC))) begin
                  if (cyc.is_read) begin
                     rd_data <= flash_dq_in;
                  end
                  flash_we_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  bus_state <= B_HOLD;
               end
            end
            default: begin
               flash_ce_n <= 1'b1;
               flash_dq_oe <= 1'b0;
               if (cyc.last) begin
                  done <= 1'b1;
                  req_ready <= 1'b1;
                  bus_state <= B_IDLE;
               end else begin
                  step <= step + 3'h1;
                  bus_state <= B_SETUP;
               end
            end
         endcase
      end
   end

   wire finishing = (bus_state == B_HOLD) && cyc.last;

   // Erase tracking: the sector under erase, the time-out window, the suspend latency
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         es_state <= E_IDLE;
         erase_addr <= 21'h000000;
         tmo <= 16'h0000;
         wait_cnt <= 16'h0000;
         bypass_active <= 1'b0;
         erase_busy <= 1'b0;
      end else begin
         if (tmo != 16'h0000) begin
            tmo <= tmo - 16'h0001;
         end
         if (es_state == E_SUSPENDING) begin
            wait_cnt <= wait_cnt - 16'h0001;
            // Full worst-case wait; polling would be faster but costs bus cycles
            if (wait_cnt == 16'h0001) begin
               es_state <= E_SUSPENDED;
               erase_busy <= 1'b0;
            end
         end
         if (finishing) begin
            case (cur.op)
               OP_SECTOR_ERASE: begin
                  es_state <= E_ERASING;
                  erase_addr <= cur.addr;
                  erase_busy <= 1'b1;
                  tmo <= 16'(ERASE_WINDOW);
               end
               OP_SUSPEND: begin
                  tmo <= 16'h0000;
                  if (tmo != 16'h0000) begin
                     es_state <= E_SUSPENDED;
                     erase_busy <= 1'b0;
                  end else begin
                     es_state <= E_SUSPENDING;
                     wait_cnt <= 16'(SUSPEND_WAIT);
                  end
               end
               OP_RESUME: begin
                  es_state <= E_ERASING;
                  erase_busy <= 1'b1;
               end
               OP_BYPASS_ENTER: bypass_active <= 1'b1;
               OP_BYPASS_EXIT: bypass_active <= 1'b0;
               default: begin
                  // Polling bit reads one at the erased sector once the erase is over
                  if (es_state == E_ERASING && rd_data[POLL_BIT] &&
                      cur.addr[SECTOR_HI:SECTOR_LO] == erase_addr[SECTOR_HI:SECTOR_LO]) begin
                     es_state <= E_IDLE;
                     erase_busy <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   a_suspend_when_erasing: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(flash_we_n) && cur.op == OP_SUSPEND) |-> es_state == E_ERASING &&
      flash_dq_out[7:0] == 8'hb0)
      else $error("suspend written outside sector erase");
   a_suspend_bank_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(flash_we_n) && cur.op == OP_SUSPEND) |->
      flash_addr[BANK_HI:BANK_LO] == erase_addr[BANK_HI:BANK_LO])
      else $error("suspend bank differs from erased bank");
   a_resume_bank_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(flash_we_n) && cur.op == OP_RESUME) |-> es_state == E_SUSPENDED &&
      flash_dq_out[7:0] == 8'h30 && flash_addr[BANK_HI:BANK_LO] == erase_addr[BANK_HI:BANK_LO])
      else $error("bad resume write");
   a_no_prog_suspended: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(flash_we_n) && cur.op == OP_BYPASS_PROG) |-> !erase_suspended && !erase_busy)
      else $error("program issued with erase pending");
   a_bypass_prog_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(flash_we_n) && cur.op == OP_BYPASS_PROG && step == 3'h0) |->
      flash_dq_out[7:0] == 8'ha0 ##7 ($fell(flash_we_n) && flash_addr == cur.addr &&
      flash_dq_out == cur.data))
      else $error("bypass program cycles wrong");
   a_bypass_exit_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(flash_we_n) && cur.op == OP_BYPASS_EXIT) |->
      flash_dq_out[7:0] == (step == 3'h0 ? 8'h90 : 8'h00))
      else $error("bypass exit data wrong");
   a_erase_last_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(flash_we_n) && cur.op == OP_SECTOR_ERASE && step == 3'h5) |->
      flash_dq_out[7:0] == 8'h30 && flash_addr == cur.addr && $past(step, 8) == 3'h4)
      else $error("sector erase sixth cycle wrong");
   a_we_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n)[*5] ##1 flash_we_n)
      else $error("write strobe width wrong");
   a_window_suspend: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (finishing && cur.op == OP_SUSPEND && tmo != 16'h0000) |=> es_state == E_SUSPENDED)
      else $error("suspend in window not immediate");
endmodule : fes_host

// ===== verification/fes_flash_model.sv
// Behavioural flash device: command decoder, sector erase with suspend/resume, bypass program.
// Assumes the host moves the pins synchronously to ref_clk; one write is taken per we_n rise.
`timescale 1ns/100ps
module fes_flash_model
   import fes_pkg::*;
#(
   parameter int TMO = 30,
   parameter int SUSP_LAT = 12,
   parameter int ERASE_LEN = 300,
   // Identification word returned in autoselect; the value is arbitrary
   parameter logic [15:0] ASEL_CODE = 16'h1c3e
) (
   input wire logic ref_clk,
   input wire logic [20:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   output logic [15:0] flash_dq_in
);
   typedef enum logic [1:0] {E_IDLE, E_WIN, E_RUN, E_SUSP} fes_ers_t;
   fes_ers_t ers = E_IDLE;
   logic [15:0] mem [logic [20:0]];
   logic [20:0] sa = '0;
   logic [2:0] step = '0;
   logic bypass = 1'b0, pend_prog = 1'b0, pend_exit = 1'b0, tog = 1'b0, susp_req = 1'b0;
   logic we_q = 1'b1, oe_q = 1'b1;
   logic asel = 1'b0;
   int cnt = 0, left = 0;
   logic [7:0] d8;
   logic in_sec, bank_ok;
   logic [15:0] rd_val;
   initial flash_dq_in = 16'h5a5a;
   assign d8 = flash_dq_out[7:0];
   assign in_sec = flash_addr[SECTOR_HI:SECTOR_LO] == sa[SECTOR_HI:SECTOR_LO];
   assign bank_ok = flash_addr[BANK_HI:BANK_LO] == sa[BANK_HI:BANK_LO];
   always @* begin
      // Codes are not array data, so they win even inside erasing sectors
      if (asel)
         rd_val = ASEL_CODE;
      else if (ers != E_IDLE && in_sec)
         rd_val = {8'h00, ers == E_SUSP, tog & (ers != E_SUSP), 3'b000, tog, 2'b00};
      else if (mem.exists(flash_addr))
         rd_val = mem[flash_addr];
      else
         rd_val = 16'hffff;
   end
   always @(posedge ref_clk) begin
      we_q <= flash_we_n;
      oe_q <= flash_oe_n;
      if (oe_q && !flash_oe_n && !flash_ce_n) tog <= ~tog;
      // A released bus never holds its last value
      flash_dq_in <= flash_dq_oe ? flash_dq_out :
         (!flash_oe_n && !flash_ce_n) ? rd_val : ~flash_dq_in;
      case (ers)
         E_WIN: if (cnt >= TMO) ers <= E_RUN; else cnt <= cnt + 1;
         E_RUN: begin
            if (susp_req && cnt >= SUSP_LAT) begin
               ers <= E_SUSP;
               susp_req <= 1'b0;
            end else if (left == 0) ers <= E_IDLE;
            else begin
               left <= left - 1;
               cnt <= cnt + 1;
            end
         end
         default: ;
      endcase
      if (!we_q && flash_we_n && !flash_ce_n) begin
         // Only program and exit decode in bypass, so a suspend there falls away
         if (bypass) begin
            pend_exit <= 1'b0;
            if (pend_prog) begin
               // Programs finish in their write and leave ers alone, so no status is pending
               mem[flash_addr] = flash_dq_out;
               pend_prog <= 1'b0;
            end else if (d8 == DATA_BYPASS_PROG[7:0]) pend_prog <= 1'b1;
            else if (d8 == DATA_BYPASS_EXIT1[7:0]) pend_exit <= 1'b1;
            else if (pend_exit && d8 == DATA_BYPASS_EXIT2[7:0]) bypass <= 1'b0;
         end else if (ers == E_WIN || ers == E_RUN) begin
            // Only suspend counts while erasing, so repeated resumes fall away
            if (d8 == DATA_SUSPEND[7:0] && bank_ok) begin
               if (ers == E_WIN) ers <= E_SUSP;
               else begin
                  susp_req <= 1'b1;
                  cnt <= 0;
               end
            end
         end else if (asel) begin
            // Leaving autoselect keeps ers, so a suspended erase stays suspended
            if (d8 == 8'hf0) asel <= 1'b0;
         end else if (ers == E_SUSP && step == 3'd0 && d8 == DATA_RESUME[7:0] && bank_ok) begin
            ers <= E_RUN;
         end else begin
            step <= '0;
            case (step)
               3'd0, 3'd3: if (flash_addr == ADDR_UNLOCK1 && d8 == DATA_UNLOCK1[7:0])
                  step <= step + 3'd1;
               3'd1, 3'd4: if (flash_addr == ADDR_UNLOCK2 && d8 == DATA_UNLOCK2[7:0])
                  step <= step + 3'd1;
               3'd2: if (d8 == DATA_ERASE_SETUP[7:0]) step <= 3'd3;
                  else if (d8 == DATA_BYPASS_ENTER[7:0]) bypass <= 1'b1;
                  else if (d8 == 8'h90) asel <= 1'b1;
               default: if (ers == E_IDLE && d8 == DATA_SECTOR_ERASE[7:0]) begin
                  ers <= E_WIN;
                  sa <= flash_addr;
                  cnt <= 0;
                  left <= ERASE_LEN;
               end
            endcase
         end
      end
   end
endmodule : fes_flash_model

// ===== verification/flash_erase_suspend_cmd_seq_tb.sv
// Self-checking bench: host block against the behavioural flash model.
// Assumes fes_pkg and fes_flash_model are compiled first.
`timescale 1ns/100ps
module flash_erase_suspend_cmd_seq_tb
   import fes_pkg::*;
;
   localparam int SW = 20;
   typedef struct packed {logic refd; logic [15:0] data; logic [15:0] mask;} fes_exp_t;
   logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
   fes_req_t req = '0;
   logic req_ready, done, refused, erase_busy, erase_suspended, bypass_active;
   logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
   logic [15:0] rd_data, flash_dq_out, flash_dq_in, pd;
   logic [20:0] flash_addr, pa;
   logic [31:0] seed = 32'hc858;
   int miscompares = 0, samples_checked = 0, n;
   fes_exp_t exp_q[$];
   fes_exp_t e;
   fes_host #(.SUSPEND_WAIT(SW), .ERASE_WINDOW(30)) DUT (.ref_clk, .rst_n, .req_valid, .req,
      .req_ready, .done, .refused, .rd_data, .erase_busy, .erase_suspended, .bypass_active,
      .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n,
      .flash_oe_n);
   fes_flash_model #(.TMO(30), .SUSP_LAT(12), .ERASE_LEN(300)) flash (.ref_clk, .flash_addr,
      .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_in);
   initial forever #4 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic cmp_flag(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : cmp_flag
   task automatic cmp_data(input logic [15:0] got, input logic [15:0] want);
      samples_checked++;
      if (got !== want) begin
         miscompares++;
         $display("wrong value at %0t: rd_data %h, expected %h", $time, got, want);
      end
   endtask : cmp_data
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // One request, held for one clock edge without a look at req_ready; the monitor checks the answer
   task automatic issue(input fes_op_t op, input logic [20:0] a, input logic [15:0] d,
         input logic refd, input logic [15:0] ed, input logic [15:0] m);
      int k;
      k = 0;
      exp_q.push_back('{refd, ed, m});
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= '{op: op, addr: a, data: d};
      @(posedge ref_clk);
      req_valid <= 1'b0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (done !== 1'b1 && refused !== 1'b1 && k < 3000);
      if (done !== 1'b1 && refused !== 1'b1) cmp_flag(1'b0, "no answer");
   endtask : issue
   task automatic wait_susp(input int lim);
      int k;
      k = 0;
      while (erase_suspended !== 1'b1 && k < lim) begin
         @(negedge ref_clk);
         k++;
      end
      cmp_flag(erase_suspended === 1'b1, "suspend late");
   endtask : wait_susp
   always @(negedge ref_clk) begin
      if (done === 1'b1 || refused === 1'b1) begin
         if (exp_q.size() == 0) cmp_flag(1'b0, "unexpected answer");
         else begin
            e = exp_q.pop_front();
            cmp_flag(refused === e.refd, "refused flag");
            cmp_data(rd_data & e.mask, e.data & e.mask);
         end
      end
   end
   // About 600 cycles are needed; over thirty times that means a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      cmp_flag(req_ready === 1'b1 && erase_busy === 1'b0 && bypass_active === 1'b0, "reset");
      issue(OP_SUSPEND, '0, '0, 1'b1, '0, '0);
      issue(OP_RESUME, '0, '0, 1'b1, '0, '0);
      issue(OP_BYPASS_PROG, '0, '0, 1'b1, '0, '0);
      issue(fes_op_t'(7'h03), '0, '0, 1'b1, '0, '0);
      $display("test refusals finished");
      issue(OP_BYPASS_ENTER, '0, '0, 1'b0, '0, '0);
      cmp_flag(bypass_active === 1'b1, "bypass on");
      issue(OP_SECTOR_ERASE, 21'h001000, '0, 1'b1, '0, '0);
      repeat (3) begin
         seed = xs(seed);
         pa = {3'h4, seed[17:0]};
         pd = seed[31:16];
         issue(OP_BYPASS_PROG, pa, pd, 1'b0, '0, '0);
         issue(OP_READ, pa, '0, 1'b0, pd, 16'hffff);
      end
      issue(OP_BYPASS_EXIT, '0, '0, 1'b0, '0, '0);
      cmp_flag(bypass_active === 1'b0, "bypass off");
      issue(OP_BYPASS_PROG, pa, pd, 1'b1, '0, '0);
      $display("test bypass finished");
      issue(OP_SECTOR_ERASE, 21'h001000, '0, 1'b0, '0, '0);
      cmp_flag(erase_busy === 1'b1, "erase busy");
      issue(OP_SUSPEND, '0, '0, 1'b0, '0, '0);
      wait_susp(3);
      issue(OP_READ, 21'h001005, '0, 1'b0, 16'h0080, 16'h0080);
      issue(OP_READ, pa, '0, 1'b0, pd, 16'hffff);
      issue(OP_RESUME, '0, '0, 1'b0, '0, '0);
      issue(OP_RESUME, '0, '0, 1'b1, '0, '0);
      issue(OP_READ, 21'h001000, '0, 1'b0, 16'h0000, 16'h0080);
      issue(OP_SUSPEND, '0, '0, 1'b0, '0, '0);
      cmp_flag(erase_suspended === 1'b0, "early suspend");
      wait_susp(SW + 4);
      issue(OP_RESUME, '0, '0, 1'b0, '0, '0);
      n = 0;
      while (erase_busy === 1'b1 && n < 60) begin
         issue(OP_READ, 21'h001000, '0, 1'b0, '0, '0);
         n++;
      end
      repeat (2) @(negedge ref_clk);
      cmp_flag(erase_busy === 1'b0, "erase end");
      issue(OP_READ, 21'h001000, '0, 1'b0, 16'hffff, 16'hffff);
      $display("test erase suspend finished");
      @(posedge ref_clk);
      cmp_flag(exp_q.size() == 0, "answers missing");
      tally_and_finish();
   end
endmodule : flash_erase_suspend_cmd_seq_tb
